// *** logic/srb_bank.sv ***
// Pointer-addressed register bank of a temperature sensor, byte level.
// Assumes an outside framing layer on lnk_clk that delivers address events,
// data bytes and stop, and a converter on sys_clk that delivers results.
//
// Summary of operation
// - Stored pointer selects temp, conf, release, over-limit, maker; 04h/06h reserved.
// - Conf and maker code are one byte; temp and set-points are two bytes.
// - A two-byte read cut short leaves the data line held low.
// - First byte after write address is the 8-bit pointer.
// - Pointer is kept, so reads without pointer repeat the last register.
// - Pointer resets to zero, selecting the temperature register.
// - Reset loads over-limit 5000h, release 4B00h, configuration 00h.
// - Maker code register is one fixed read-only byte.
// - Configuration is a plain 8-bit byte, written and read back.
// - Configuration bit 7 is reserved read/write, resets to zero.
// - Bits 6:5 pick 10, 0.125, 1 or 30 conversions per second.
// - Bits 4:3 pick 1, 2, 4 or 6 consecutive faults.
// - Bit 2 picks alert polarity, zero active low.
// - Bit 1 picks alert mode, zero comparator, one interrupt.
// - Bit 0 set enters shutdown, cleared returns to normal.
// - Temperature register updates at the end of every conversion.
// - Temperature is read-only, 13-bit two's complement, 0.03125 degree steps.
// - Temperature left-justified, sign at upper bit 7, low bits zero.
// - Set-points hold 9 left-justified bits; low 7 bits read zero.
`timescale 1ns/100ps
`include "srb_regs.svh"

module srb_bank
    import srb_pkg::*;
(
    input wire logic sys_clk, // System clock, 200 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic conv_done, // Conversion finished, one-cycle pulse
    input wire logic [12:0] conv_result, // Result, valid with conv_done
    output logic [1:0] sample_rate_sel, // Conversion rate code
    output logic [1:0] fault_count_sel, // Fault queue code
    output logic [2:0] fault_limit, // Decoded consecutive-fault count
    output logic alert_polarity, // One: alert active high
    output logic alert_mode_sel, // One: interrupt mode
    output logic shutdown, // One: conversions stopped
    output logic [8:0] over_limit_level, // Over-limit set-point
    output logic [8:0] release_level, // Release set-point
    output logic reg_read_pulse, // Any register read began
    input wire logic lnk_clk, // Link clock from the master side
    input wire logic lnk_start_wr, // Write address accepted, pulse
    input wire logic lnk_start_rd, // Read address accepted, pulse
    input wire logic lnk_wr_valid, // Write byte offered
    input wire logic [7:0] lnk_wr_byte, // Write byte
    output logic lnk_wr_ready, // Write byte may be taken
    input wire logic lnk_rd_req, // Master takes a read byte
    output logic lnk_rd_valid, // Read byte is ready
    output logic [7:0] lnk_rd_byte, // Read byte
    input wire logic lnk_stop, // Transfer ended, pulse
    output logic lnk_sda_hold // Data line held low
);

    // Link domain reset: asserted at once, released on lnk_clk
    logic lnk_rst_meta_q;
    logic lnk_rstn_q;

    always_ff @(posedge lnk_clk or negedge rstn) begin
        if (!rstn) begin
            lnk_rst_meta_q <= 1'b0;
            lnk_rstn_q <= 1'b0;
        end else begin
            lnk_rst_meta_q <= 1'b1;
            lnk_rstn_q <= lnk_rst_meta_q;
        end
    end

    // Link domain state
    srb_lstate_t lstate_q, lstate_d;
    logic [7:0] ptr_q, ptr_d;
    logic [7:0] hi_q, hi_d;
    srb_wreq_t wreq_q, wreq_d;
    logic wtgl_q, wtgl_d;
    logic rtgl_q, rtgl_d;
    logic idx_q, idx_d;
    logic have_q, have_d;
    logic pend_q, pend_d;
    logic hold_q, hold_d;
    logic [7:0] rd_byte_q, rd_byte_d;
    logic wack_meta_q, wack_q;
    logic rack_meta_q, rack_q;

    // System domain state
    logic wtgl_meta_q, wtgl_s_q, wtgl_d_q;
    logic rtgl_meta_q, rtgl_s_q, rtgl_d_q;
    srb_conf_t conf_q, conf_d;
    logic [8:0] over_q, over_d;
    logic [8:0] rel_q, rel_d;
    logic [12:0] temp_q, temp_d;
    logic [15:0] snap_q, snap_d;
    logic [2:0] limit_q, limit_d;
    logic read_q;

    // Link side decode
    wire logic ptr_two = srb_two_byte(ptr_q);
    wire logic wr_idle = (wack_q == wtgl_q);
    wire logic wr_take = lnk_wr_valid && wr_idle;
    wire logic snap_ok = (rack_q == rtgl_q);
    wire logic rd_take = lnk_rd_req && lnk_rd_valid;
    wire logic in_read = (lstate_q == LS_READ);

    assign lnk_wr_ready = wr_idle;
    assign lnk_rd_valid = in_read && have_q;
    assign lnk_rd_byte = rd_byte_q;
    assign lnk_sda_hold = hold_q;

    always_comb begin
        lstate_d = lstate_q;
        ptr_d = ptr_q;
        hi_d = hi_q;
        wreq_d = wreq_q;
        wtgl_d = wtgl_q;
        rtgl_d = rtgl_q;
        idx_d = idx_q;
        have_d = have_q;
        pend_d = pend_q;
        hold_d = hold_q;
        rd_byte_d = rd_byte_q;
        if (lnk_start_wr) begin
            lstate_d = LS_PTR;
            hold_d = 1'b0;
            pend_d = 1'b0;
        end else if (lnk_start_rd) begin
            // Snapshot of the register named by the kept pointer
            lstate_d = LS_READ;
            rtgl_d = ~rtgl_q;
            idx_d = 1'b0;
            have_d = 1'b0;
            hold_d = 1'b0;
            pend_d = 1'b0;
        end else if (lnk_stop) begin
            // Upper byte out but lower not yet taken: keep line low
            if (pend_q) begin
                hold_d = 1'b1;
            end else begin
                lstate_d = LS_IDLE;
            end
        end else begin
            unique case (lstate_q)
                LS_IDLE: begin
                end
                LS_PTR: begin
                    if (wr_take) begin
                        ptr_d = lnk_wr_byte;
                        lstate_d = LS_DATA_HI;
                    end
                end
                LS_DATA_HI: begin
                    if (wr_take) begin
                        if (ptr_two) begin
                            hi_d = lnk_wr_byte;
                            lstate_d = LS_DATA_LO;
                        end else begin
                            wreq_d = '{ptr: ptr_q, data: {lnk_wr_byte, 8'h00}};
                            wtgl_d = ~wtgl_q;
                        end
                    end
                end
                LS_DATA_LO: begin
                    if (wr_take) begin
                        wreq_d = '{ptr: ptr_q, data: {hi_q, lnk_wr_byte}};
                        wtgl_d = ~wtgl_q;
                        lstate_d = LS_DATA_HI;
                    end
                end
                LS_READ: begin
                    if (!have_q && snap_ok) begin
                        rd_byte_d = snap_q[15:8];
                        have_d = 1'b1;
                    end else if (rd_take) begin
                        if (ptr_two && !idx_q) begin
                            rd_byte_d = snap_q[7:0];
                            idx_d = 1'b1;
                            pend_d = 1'b1;
                        end else begin
                            // Further bytes wrap back to the upper byte
                            rd_byte_d = snap_q[15:8];
                            idx_d = 1'b0;
                            pend_d = 1'b0;
                            if (hold_q) begin
                                hold_d = 1'b0;
                                lstate_d = LS_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge lnk_clk or negedge lnk_rstn_q) begin
        if (!lnk_rstn_q) begin
            lstate_q <= LS_IDLE;
            ptr_q <= `SRB_PTR_RESET;
            hi_q <= 8'h00;
            wreq_q <= '0;
            wtgl_q <= 1'b0;
            rtgl_q <= 1'b0;
            idx_q <= 1'b0;
            have_q <= 1'b0;
            pend_q <= 1'b0;
            hold_q <= 1'b0;
            rd_byte_q <= 8'h00;
        end else begin
            lstate_q <= lstate_d;
            ptr_q <= ptr_d;
            hi_q <= hi_d;
            wreq_q <= wreq_d;
            wtgl_q <= wtgl_d;
            rtgl_q <= rtgl_d;
            idx_q <= idx_d;
            have_q <= have_d;
            pend_q <= pend_d;
            hold_q <= hold_d;
            rd_byte_q <= rd_byte_d;
        end
    end

    // Acknowledge toggles back from the system domain
    always_ff @(posedge lnk_clk or negedge lnk_rstn_q) begin
        if (!lnk_rstn_q) begin
            wack_meta_q <= 1'b0;
            wack_q <= 1'b0;
            rack_meta_q <= 1'b0;
            rack_q <= 1'b0;
        end else begin
            wack_meta_q <= wtgl_d_q;
            wack_q <= wack_meta_q;
            rack_meta_q <= rtgl_d_q;
            rack_q <= rack_meta_q;
        end
    end

    // Request toggles into the system domain; payloads held until acknowledged
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wtgl_meta_q <= 1'b0;
            wtgl_s_q <= 1'b0;
            wtgl_d_q <= 1'b0;
            rtgl_meta_q <= 1'b0;
            rtgl_s_q <= 1'b0;
            rtgl_d_q <= 1'b0;
        end else begin
            wtgl_meta_q <= wtgl_q;
            wtgl_s_q <= wtgl_meta_q;
            wtgl_d_q <= wtgl_s_q;
            rtgl_meta_q <= rtgl_q;
            rtgl_s_q <= rtgl_meta_q;
            rtgl_d_q <= rtgl_s_q;
        end
    end

    wire logic wr_fire = wtgl_s_q ^ wtgl_d_q;
    wire logic rd_fire = rtgl_s_q ^ rtgl_d_q;
    wire logic wr_conf = wr_fire && (wreq_q.ptr == `SRB_PTR_CONF);
    wire logic wr_rel = wr_fire && (wreq_q.ptr == `SRB_PTR_REL);
    wire logic wr_over = wr_fire && (wreq_q.ptr == `SRB_PTR_OVER);

    // Read word; ptr_q is stable for the whole read handshake
    wire logic [15:0] temp_word = {temp_q, 3'b000};
    wire logic [15:0] over_word = {over_q, 7'h00};
    wire logic [15:0] rel_word = {rel_q, 7'h00};
    wire logic [15:0] conf_word = {conf_q, 8'h00};
    wire logic [15:0] maker_word = {`SRB_MAKER_CODE, 8'h00};
    wire logic [15:0] rsvd_word = {`SRB_RSVD_READ, 8'h00};
    wire logic [15:0] rd_word =
        (ptr_q == `SRB_PTR_TEMP) ? temp_word :
        (ptr_q == `SRB_PTR_CONF) ? conf_word :
        (ptr_q == `SRB_PTR_REL) ? rel_word :
        (ptr_q == `SRB_PTR_OVER) ? over_word :
        (ptr_q == `SRB_PTR_MAKER) ? maker_word : rsvd_word;

    wire logic [7:0] conf_in = wreq_q.data[15:8];
    wire logic [1:0] fq_next = conf_d.fault_count_sel;

    always_comb begin
        // Unmatched pointers leave every register untouched
        conf_d = wr_conf ? srb_conf_t'(conf_in) : conf_q;
        rel_d = wr_rel ? wreq_q.data[15:`SRB_SETPT_LSB] : rel_q;
        over_d = wr_over ? wreq_q.data[15:`SRB_SETPT_LSB] : over_q;
        temp_d = conv_done ? conv_result : temp_q;
        snap_d = rd_fire ? rd_word : snap_q;
        unique case (fq_next)
            2'b00: limit_d = `SRB_FQ_CODE0;
            2'b01: limit_d = `SRB_FQ_CODE1;
            2'b10: limit_d = `SRB_FQ_CODE2;
            2'b11: limit_d = `SRB_FQ_CODE3;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            conf_q <= srb_conf_t'(`SRB_CONF_RESET);
            over_q <= 9'(`SRB_OVER_RESET >> `SRB_SETPT_LSB);
            rel_q <= 9'(`SRB_REL_RESET >> `SRB_SETPT_LSB);
            temp_q <= `SRB_TEMP_RESET;
            snap_q <= 16'h0000;
            limit_q <= `SRB_FQ_CODE0;
            read_q <= 1'b0;
        end else begin
            conf_q <= conf_d;
            over_q <= over_d;
            rel_q <= rel_d;
            temp_q <= temp_d;
            snap_q <= snap_d;
            limit_q <= limit_d;
            read_q <= rd_fire;
        end
    end

    assign sample_rate_sel = conf_q.sample_rate_sel;
    assign fault_count_sel = conf_q.fault_count_sel;
    assign fault_limit = limit_q;
    assign alert_polarity = conf_q.alert_polarity;
    assign alert_mode_sel = conf_q.alert_mode_sel;
    assign shutdown = conf_q.shutdown;
    assign over_limit_level = over_q;
    assign release_level = rel_q;
    // Lets the alert logic clear an interrupt-mode alert on any read
    assign reg_read_pulse = read_q;

    chk_reset_values: assert property (
        @(posedge sys_clk) $rose(rstn) |->
            over_word == `SRB_OVER_RESET && rel_word == `SRB_REL_RESET)
        else $error("set-point reset values wrong");

    chk_conf_write: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        wr_conf |=> conf_q == $past(conf_in) && !shutdown == !$past(conf_in[0]))
        else $error("configuration write not stored");

    chk_ignore_ro: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (wr_fire && !wr_conf && !wr_rel && !wr_over) |=>
            $stable(conf_q) && $stable(over_q) && $stable(rel_q))
        else $error("read-only write changed state");

    chk_temp_update: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        conv_done |=> temp_q == $past(conv_result))
        else $error("temperature not updated");

    chk_temp_layout: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (rd_fire && ptr_q == `SRB_PTR_TEMP && !conv_done) |=>
            snap_q[15:`SRB_TEMP_LSB] == temp_q && snap_q[2:0] == 3'b000)
        else $error("temperature layout wrong");

    chk_setpt_low: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (rd_fire && (ptr_q == `SRB_PTR_REL || ptr_q == `SRB_PTR_OVER)) |=>
            snap_q[6:0] == 7'h00)
        else $error("set-point low bits not zero");

    chk_fault_six: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (wr_conf && conf_in[4:3] == 2'b11) |=> fault_limit == 3'h6)
        else $error("fault count not six");

    chk_read_pulse: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_fire |=> reg_read_pulse ##1 !reg_read_pulse)
        else $error("read pulse wrong");

    chk_ptr_source: assert property (
        @(posedge lnk_clk) disable iff (!lnk_rstn_q)
        $changed(ptr_q) |-> $past(lstate_q) == LS_PTR && $past(wr_take))
        else $error("pointer changed outside pointer byte");

    chk_sda_hold: assert property (
        @(posedge lnk_clk) disable iff (!lnk_rstn_q)
        (lnk_stop && pend_q && !lnk_start_wr && !lnk_start_rd) |=>
            lnk_sda_hold && in_read)
        else $error("line not held after short read");

    chk_upper_first: assert property (
        @(posedge lnk_clk) disable iff (!lnk_rstn_q)
        (in_read && !have_q && snap_ok && !lnk_start_rd && !lnk_start_wr && !lnk_stop)
            |=> lnk_rd_valid && lnk_rd_byte == snap_q[15:8])
        else $error("upper byte not first");

endmodule

// *** logic/srb_regs.svh ***
// Register map, field positions and reset values of the sensor register bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef SRB_REGS_SVH
`define SRB_REGS_SVH

// Pointer values
`define SRB_PTR_TEMP 8'h00
`define SRB_PTR_CONF 8'h01
`define SRB_PTR_REL 8'h02
`define SRB_PTR_OVER 8'h03
`define SRB_PTR_RSVA 8'h04
`define SRB_PTR_MAKER 8'h05
`define SRB_PTR_RSVB 8'h06

// Reset values
`define SRB_PTR_RESET 8'h00
`define SRB_CONF_RESET 8'h00
`define SRB_OVER_RESET 16'h5000
`define SRB_REL_RESET 16'h4B00
`define SRB_TEMP_RESET 13'h0000
// Arbitrary neutral value
`define SRB_MAKER_CODE 8'h5C
`define SRB_RSVD_READ 8'h00

// Field positions in the two-byte words
`define SRB_TEMP_LSB 3
`define SRB_SETPT_LSB 7

// Consecutive-fault counts per code
`define SRB_FQ_CODE0 3'h1
`define SRB_FQ_CODE1 3'h2
`define SRB_FQ_CODE2 3'h4
`define SRB_FQ_CODE3 3'h6

`endif

// *** logic/srb_pkg.sv ***
// Types shared by the sensor register bank.
// Assumes the constants header sits beside it on the include path.
package srb_pkg;
    `include "srb_regs.svh"

    // Configuration byte, bit 7 down to bit 0
    typedef struct packed {
        logic rsvd;
        logic [1:0] sample_rate_sel;
        logic [1:0] fault_count_sel;
        logic alert_polarity;
        logic alert_mode_sel;
        logic shutdown;
    } srb_conf_t;

    // Write request handed from link domain to system domain
    typedef struct packed {
        logic [7:0] ptr;
        logic [15:0] data;
    } srb_wreq_t;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_PTR,
        LS_DATA_HI,
        LS_DATA_LO,
        LS_READ
    } srb_lstate_t;

    function automatic logic srb_two_byte(input logic [7:0] p);
        return (p == `SRB_PTR_TEMP) || (p == `SRB_PTR_REL) || (p == `SRB_PTR_OVER);
    endfunction
endpackage

// *** test/srb_link_master.sv ***
// Byte-level bus master model driving the link side of the register bank.
// Assumes a free-running link clock and a bank already out of reset.
`timescale 1ns/100ps
module srb_link_master (
    input wire logic lnk_clk, // Link clock
    output logic lnk_start_wr, // Write address pulse
    output logic lnk_start_rd, // Read address pulse
    output logic lnk_wr_valid, // Write byte offered
    output logic [7:0] lnk_wr_byte, // Write byte
    input wire logic lnk_wr_ready, // Bank may take byte
    output logic lnk_rd_req, // Take read byte
    input wire logic lnk_rd_valid, // Read byte ready
    input wire logic [7:0] lnk_rd_byte, // Read byte
    output logic lnk_stop // Transfer end pulse
);
    int hangs = 0;
    initial begin
        {lnk_start_wr, lnk_start_rd, lnk_wr_valid, lnk_rd_req, lnk_stop} = 5'h00;
        lnk_wr_byte = 8'hA5;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge lnk_clk);
        #1;
    endtask
    // Ends at the edge where ready (rd=0) or read valid (rd=1) is high
    task automatic wait_hi(input bit rd);
        int k;
        k = 0;
        @(posedge lnk_clk);
        while (!(rd ? lnk_rd_valid : lnk_wr_ready) && k < 300) begin
            k++;
            @(posedge lnk_clk);
        end
        if (k == 300) hangs++;
    endtask
    task automatic send(input logic [7:0] b);
        lnk_wr_valid = 1'b1;
        lnk_wr_byte = b;
        wait_hi(0);
        #1;
        lnk_wr_valid = 1'b0;
        // Released lane shows the inverse so a stale byte is never taken
        lnk_wr_byte = ~b;
        // One idle edge, so valid never falls and rises in one step
        tick(1);
    endtask
    task automatic finish();
        lnk_stop = 1'b1;
        tick(1);
        lnk_stop = 1'b0;
        tick(8);
    endtask
    task automatic write_reg(input logic [7:0] p, input int n, input logic [15:0] d);
        tick(1);
        lnk_start_wr = 1'b1;
        tick(1);
        lnk_start_wr = 1'b0;
        send(p);
        if (n == 2) send(d[15:8]);
        if (n > 0) send(d[7:0]);
        tick(2);
        wait_hi(0);
        #1;
        finish();
    endtask
    task automatic begin_read();
        tick(1);
        lnk_start_rd = 1'b1;
        tick(1);
        lnk_start_rd = 1'b0;
    endtask
    // Request held across bytes; newest byte lands lowest
    task automatic take(input int n, output logic [15:0] d);
        d = 16'h0000;
        lnk_rd_req = 1'b1;
        for (int i = 0; i < n; i++) begin
            wait_hi(1);
            d = {d[7:0], lnk_rd_byte};
        end
        #1;
        lnk_rd_req = 1'b0;
    endtask
    task automatic read_reg(input int n, output logic [15:0] d);
        begin_read();
        take(n, d);
        finish();
    endtask
endmodule

// *** test/sensor_register_bank_tb.sv ***
// Self-checking bench: register bank against a reference model of the map.
// Assumes the bank, its package and the link master model compile first.
`timescale 1ns/100ps
`include "srb_regs.svh"
module sensor_register_bank_tb;
    logic sys_clk = 1'b0, lnk_clk = 1'b0, rstn = 1'b0, conv_done = 1'b0;
    logic [12:0] conv_result = 13'h0000;
    logic [1:0] sample_rate_sel, fault_count_sel;
    logic [2:0] fault_limit;
    logic alert_polarity, alert_mode_sel, shutdown, reg_read_pulse;
    logic [8:0] over_limit_level, release_level;
    logic lnk_start_wr, lnk_start_rd, lnk_wr_valid, lnk_wr_ready, lnk_rd_req;
    logic lnk_rd_valid, lnk_stop, lnk_sda_hold;
    logic [7:0] lnk_wr_byte, lnk_rd_byte;
    int bad_count = 0, checked = 0, seed = 29;
    int reads = 0, pulses = 0;
    int fq[4] = '{1, 2, 4, 6};
    logic [7:0] m_conf = 8'h00, m_ptr = 8'h00;
    logic [15:0] m_over = 16'h5000, m_rel = 16'h4B00, m_temp = 16'h0000, d;
    always #2.5 sys_clk = ~sys_clk;
    always #40 lnk_clk = ~lnk_clk;
    // One pulse per read start is expected
    always @(posedge sys_clk) begin
        if (reg_read_pulse === 1'b1) pulses++;
    end
    srb_bank u_srb_bank (.sys_clk, .rstn, .conv_done, .conv_result, .sample_rate_sel,
        .fault_count_sel, .fault_limit, .alert_polarity, .alert_mode_sel, .shutdown,
        .over_limit_level, .release_level, .reg_read_pulse, .lnk_clk, .lnk_start_wr,
        .lnk_start_rd, .lnk_wr_valid, .lnk_wr_byte, .lnk_wr_ready, .lnk_rd_req,
        .lnk_rd_valid, .lnk_rd_byte, .lnk_stop, .lnk_sda_hold);
    srb_link_master u_srb_link_master (.lnk_clk, .lnk_start_wr, .lnk_start_rd,
        .lnk_wr_valid, .lnk_wr_byte, .lnk_wr_ready, .lnk_rd_req, .lnk_rd_valid,
        .lnk_rd_byte, .lnk_stop);
    function automatic int nbytes(input logic [7:0] p);
        return (p == 8'h00 || p == 8'h02 || p == 8'h03) ? 2 : 1;
    endfunction
    function automatic logic [15:0] expv(input logic [7:0] p);
        case (p)
            8'h00: return m_temp;
            8'h01: return {8'h00, m_conf};
            8'h02: return m_rel;
            8'h03: return m_over;
            8'h05: return {8'h00, `SRB_MAKER_CODE};
            default: return 16'h0000;
        endcase
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_outs();
        check("rate", 16'(m_conf[6:5]), 16'(sample_rate_sel));
        check("faults", 16'(m_conf[4:3]), 16'(fault_count_sel));
        check("limit", 16'(fq[m_conf[4:3]]), 16'(fault_limit));
        check("polarity", 16'(m_conf[2]), 16'(alert_polarity));
        check("mode", 16'(m_conf[1]), 16'(alert_mode_sel));
        check("shutdown", 16'(m_conf[0]), 16'(shutdown));
        check("over", 16'(m_over[15:7]), 16'(over_limit_level));
        check("release", 16'(m_rel[15:7]), 16'(release_level));
    endtask
    // Set-points keep only the nine upper bits
    task automatic wr(input logic [7:0] p, input logic [15:0] v);
        u_srb_link_master.write_reg(p, nbytes(p), v);
        m_ptr = p;
        if (p == 8'h01) m_conf = v[7:0];
        if (p == 8'h02) m_rel = v & 16'hFF80;
        if (p == 8'h03) m_over = v & 16'hFF80;
    endtask
    task automatic rd(input bit newp, input logic [7:0] p);
        if (newp) begin
            u_srb_link_master.write_reg(p, 0, 16'h0000);
            m_ptr = p;
        end
        reads++;
        u_srb_link_master.read_reg(nbytes(m_ptr), d);
        check("read", expv(m_ptr), d);
    endtask
    task automatic conv(input logic [12:0] v);
        @(posedge sys_clk);
        #1;
        conv_done = 1'b1;
        conv_result = v;
        @(posedge sys_clk);
        #1;
        conv_done = 1'b0;
        conv_result = ~v;
        m_temp = {v, 3'b000};
    endtask
    task automatic test_done();
        bad_count += u_srb_link_master.hangs;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        test_done();
    end
    initial begin
        // Held over slow link edges so both domains see reset
        repeat (5) @(posedge lnk_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge lnk_clk);
        chk_outs();
        check("ready", 16'h0001, 16'(lnk_wr_ready));
        rd(0, 8'h00);
        for (int p = 1; p < 7; p++) rd(1, 8'(p));
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, 16'(($random(seed) & 7) | (i << 5) | ((3 - i) << 3) | ((i & 1) << 7)));
            chk_outs();
            rd(0, 8'h01);
        end
        $display("test configuration done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h03, 16'($random(seed)));
            wr(8'h02, 16'($random(seed)));
            chk_outs();
            rd(1, 8'h03);
            rd(1, 8'h02);
            rd(0, 8'h00);
        end
        $display("test set-points done");
        for (int i = 0; i < 3; i++) begin
            conv(13'($random(seed)));
            rd(i == 0, 8'h00);
        end
        wr(8'h00, 16'hFFFF);
        for (int p = 4; p < 7; p++) wr(8'(p), 16'h00FF);
        rd(1, 8'h00);
        rd(1, 8'h05);
        chk_outs();
        $display("test read-only done");
        u_srb_link_master.write_reg(8'h03, 0, 16'h0000);
        reads++;
        u_srb_link_master.begin_read();
        u_srb_link_master.take(1, d);
        check("upper", {8'h00, m_over[15:8]}, d);
        u_srb_link_master.finish();
        check("hold", 16'h0001, 16'(lnk_sda_hold));
        u_srb_link_master.take(1, d);
        check("lower", {8'h00, m_over[7:0]}, d);
        u_srb_link_master.finish();
        check("hold", 16'h0000, 16'(lnk_sda_hold));
        $display("test short read done");
        check("pulses", 16'(reads), 16'(pulses));
        test_done();
    end
endmodule
